// >>> core/pmicis_consts.svh
// register offsets, field positions and reset values of the interrupt/status block
`ifndef PMICIS_CONSTS_SVH
`define PMICIS_CONSTS_SVH
`define PMICIS_ADDR_W 8
`define PMICIS_OFS_IRQ_ENABLE 8'h0A
`define PMICIS_OFS_CONFIG_LOAD 8'h0B
`define PMICIS_OFS_IRQ_FLAGS 8'h0C
`define PMICIS_OFS_STATUS 8'h0D
`define PMICIS_IRQ_ENABLE_RST 6'h01
`define PMICIS_FLAGS_RST 6'h00
`define PMICIS_RDATA_RST 8'h00
`define PMICIS_UNMAPPED_DATA 8'h00
`define PMICIS_BIT_READY 0
`define PMICIS_BIT_OVDIS 1
`define PMICIS_BIT_OVCH 2
`define PMICIS_BIT_SRC_LOW 3
`define PMICIS_BIT_TEMP 4
`define PMICIS_BIT_POWER 5
`define PMICIS_BIT_CHARGE 5
`define PMICIS_CTRL_LOAD_BIT 0
`define PMICIS_CTRL_BUSY_BIT 2
`define PMICIS_STATUS_CHARGE_BIT 6
`endif

// >>> core/pmicis_pkg.sv
// types shared by the interrupt/status block
package pmicis_pkg;
	typedef enum logic [1:0] {
		PMICIS_IDLE = 2'b00,
		PMICIS_START = 2'b01,
		PMICIS_WAIT = 2'b11
	} pmicis_copy_state_t;

	typedef struct packed {
		logic [5:0] irq_enable;
		logic cfg_load;
		pmicis_copy_state_t copy_state;
		logic copy_start;
		logic [5:0] flags;
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [5:0] lvl_prev;
		logic [7:0] rdata;
		logic irq;
	} pmicis_regs_t;
endpackage

// >>> core/pmicis_ctrl.sv
// interrupt enable, config-load control, interrupt flags and status registers
`timescale 1ns/1ps
`default_nettype none
`include "pmicis_consts.svh"
module pmicis_ctrl (
	input wire logic mclk_in, // 100 MHz clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic [7:0] reg_addr_in, // register offset from serial engine
	input wire logic reg_wr_in, // write strobe, one cycle
	input wire logic [7:0] reg_wdata_in, // write data
	input wire logic reg_rd_in, // read strobe, one cycle
	output logic [7:0] reg_rdata_out, // read data, valid cycle after strobe
	input wire logic cold_start_done_in, // async: cold start over, link usable
	input wire logic batt_below_ovdis_in, // async comparator
	input wire logic batt_above_ovch_in, // async comparator
	input wire logic source_low_in, // async: source not above sleep level
	input wire logic temp_outside_in, // async: temperature outside window
	input wire logic charge_enabled_in, // async: storage charging enabled
	input wire logic power_result_ready_in, // same-clock pulse from power meter
	input wire logic copy_done_in, // same-clock pulse: shadow copy finished
	output logic copy_start_out, // one-cycle pulse: start shadow copy
	output logic cfg_from_serial_out, // 1: serial config active, 0: pins
	output logic copy_in_progress_out, // copy busy level
	output logic irq_out // interrupt request pin, active high
);
	import pmicis_pkg::*;

	pmicis_regs_t r_reg;
	pmicis_regs_t r_next;
	logic [5:0] levels;
	logic [5:0] events;
	logic [7:0] status_val;
	logic [7:0] ctrl_val;
	logic busy;

	assign levels = {charge_enabled_in, temp_outside_in, source_low_in, batt_above_ovch_in,
		batt_below_ovdis_in, cold_start_done_in};
	assign busy = (r_reg.copy_state != PMICIS_IDLE);

	always_comb begin
		status_val = `PMICIS_RDATA_RST;
		status_val[`PMICIS_STATUS_CHARGE_BIT] = r_reg.sync2[`PMICIS_BIT_CHARGE];
		status_val[`PMICIS_BIT_TEMP] = r_reg.sync2[`PMICIS_BIT_TEMP];
		status_val[`PMICIS_BIT_SRC_LOW] = r_reg.sync2[`PMICIS_BIT_SRC_LOW];
		status_val[`PMICIS_BIT_OVCH] = r_reg.sync2[`PMICIS_BIT_OVCH];
		status_val[`PMICIS_BIT_OVDIS] = r_reg.sync2[`PMICIS_BIT_OVDIS];
		ctrl_val = `PMICIS_RDATA_RST;
		ctrl_val[`PMICIS_CTRL_LOAD_BIT] = r_reg.cfg_load;
		ctrl_val[`PMICIS_CTRL_BUSY_BIT] = busy;
	end

	always_comb begin
		r_next = r_reg;
		events = 6'h00;
		// comparators are analog, so both edges count as a crossing
		for (int i = `PMICIS_BIT_OVDIS; i <= `PMICIS_BIT_TEMP; i++) begin
			events[i] = r_reg.sync2[i] ^ r_reg.lvl_prev[i];
		end
		events[`PMICIS_BIT_READY] = r_reg.sync2[`PMICIS_BIT_READY] & ~r_reg.lvl_prev[`PMICIS_BIT_READY];
		events[`PMICIS_BIT_POWER] = power_result_ready_in;
		r_next.sync1 = levels;
		r_next.sync2 = r_reg.sync1;
		r_next.lvl_prev = r_reg.sync2;
		r_next.copy_start = 1'b0;
		r_next.rdata = r_reg.rdata;
		// set wins over clear-on-read so an event in the read cycle survives
		if (reg_rd_in && reg_addr_in == `PMICIS_OFS_IRQ_FLAGS) begin
			r_next.flags = 6'h00;
		end
		r_next.flags = r_next.flags | (events & r_reg.irq_enable);
		if (reg_wr_in) begin
			case (reg_addr_in)
				`PMICIS_OFS_IRQ_ENABLE: begin
					r_next.irq_enable = reg_wdata_in[5:0];
				end
				`PMICIS_OFS_CONFIG_LOAD: begin
					// a copy already under way is not restarted or switched
					if (!busy) begin
						r_next.cfg_load = reg_wdata_in[`PMICIS_CTRL_LOAD_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		case (r_reg.copy_state)
			PMICIS_IDLE: begin
				if (reg_wr_in && reg_addr_in == `PMICIS_OFS_CONFIG_LOAD &&
					reg_wdata_in[`PMICIS_CTRL_LOAD_BIT]) begin
					r_next.copy_state = PMICIS_START;
					r_next.copy_start = 1'b1;
				end
			end
			PMICIS_START: begin
				r_next.copy_state = PMICIS_WAIT;
			end
			PMICIS_WAIT: begin
				if (copy_done_in) begin
					r_next.copy_state = PMICIS_IDLE;
				end
			end
			default: begin
				r_next.copy_state = PMICIS_IDLE;
			end
		endcase
		if (reg_rd_in) begin
			case (reg_addr_in)
				`PMICIS_OFS_IRQ_ENABLE: r_next.rdata = {2'b00, r_reg.irq_enable};
				`PMICIS_OFS_CONFIG_LOAD: r_next.rdata = ctrl_val;
				`PMICIS_OFS_IRQ_FLAGS: r_next.rdata = {2'b00, r_reg.flags};
				`PMICIS_OFS_STATUS: r_next.rdata = status_val;
				default: r_next.rdata = `PMICIS_UNMAPPED_DATA;
			endcase
		end
		r_next.irq = |(r_next.flags & r_next.irq_enable);
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			r_reg <= '0;
			r_reg.irq_enable <= `PMICIS_IRQ_ENABLE_RST;
			r_reg.flags <= `PMICIS_FLAGS_RST;
			r_reg.copy_state <= PMICIS_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign reg_rdata_out = r_reg.rdata;
	assign copy_start_out = r_reg.copy_start;
	assign cfg_from_serial_out = r_reg.cfg_load;
	assign copy_in_progress_out = busy;
	assign irq_out = r_reg.irq;

	property p_ovdis_flag;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(r_reg.irq_enable[1] && (r_reg.sync2[1] != r_reg.lvl_prev[1]) && !(reg_wr_in && reg_addr_in == 8'h0A)) |=>
			r_reg.flags[1] && irq_out;
	endproperty
	a_ovdis_flag: assert property (p_ovdis_flag) else $error("over-discharge crossing lost");

	property p_ovdis_masked;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(!r_reg.irq_enable[1] && !r_reg.flags[1]) |=> !r_reg.flags[1];
	endproperty
	a_ovdis_masked: assert property (p_ovdis_masked) else $error("masked over-discharge flag set");

	property p_ready_default;
		@(posedge mclk_in) disable iff (!rst_n_in)
		!$past(rst_n_in) |-> r_reg.irq_enable == 6'h01 && r_reg.flags == 6'h00 && !irq_out;
	endproperty
	a_ready_default: assert property (p_ready_default) else $error("bad enable reset value");

	property p_ready_flag;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(r_reg.irq_enable[0] && r_reg.sync2[0] && !r_reg.lvl_prev[0]) |=> r_reg.flags[0];
	endproperty
	a_ready_flag: assert property (p_ready_flag) else $error("ready flag missing");

	property p_load_select;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_wr_in && reg_addr_in == 8'h0B && !busy) |=> cfg_from_serial_out == $past(reg_wdata_in[0]);
	endproperty
	a_load_select: assert property (p_load_select) else $error("config select not taken");

	property p_busy_start;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_wr_in && reg_addr_in == 8'h0B && reg_wdata_in[0] && !busy) |=>
			copy_start_out && copy_in_progress_out ##1 !copy_start_out && copy_in_progress_out;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not raised for copy");

	property p_busy_end;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(r_reg.copy_state == PMICIS_WAIT && copy_done_in) |=> !copy_in_progress_out;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy not cleared after copy");

	property p_power_flag;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(power_result_ready_in && r_reg.irq_enable[5]) |=> r_reg.flags[5];
	endproperty
	a_power_flag: assert property (p_power_flag) else $error("power result flag missing");

	property p_flag_read;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_rd_in && reg_addr_in == 8'h0C) |=> reg_rdata_out == {2'b00, $past(r_reg.flags)} &&
			r_reg.flags == ($past(events) & $past(r_reg.irq_enable));
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read or clear wrong");

	property p_status_read;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_rd_in && reg_addr_in == 8'h0D) |=> reg_rdata_out[6] == $past(r_reg.sync2[5]) &&
			reg_rdata_out[4:1] == $past(r_reg.sync2[4:1]) && reg_rdata_out[0] == 1'b0;
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_irq_level;
		@(posedge mclk_in) disable iff (!rst_n_in)
		irq_out == |(r_reg.flags & r_reg.irq_enable);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("request pin disagrees with flags");

	property p_temp_flag;
		@(posedge mclk_in) disable iff (!rst_n_in)
		($changed(r_reg.sync2[4]) && r_reg.irq_enable[4]) |=> r_reg.flags[4];
	endproperty
	a_temp_flag: assert property (p_temp_flag) else $error("temperature flag missing");

	property p_ovch_flag;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(r_reg.irq_enable[2] && (r_reg.sync2[2] != r_reg.lvl_prev[2])) |=> r_reg.flags[2];
	endproperty
	a_ovch_flag: assert property (p_ovch_flag) else $error("overcharge flag missing");

	property p_srclow_flag;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(r_reg.irq_enable[3] && (r_reg.sync2[3] != r_reg.lvl_prev[3])) |=> r_reg.flags[3];
	endproperty
	a_srclow_flag: assert property (p_srclow_flag) else $error("source low flag missing");

	property p_power_masked;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(!r_reg.irq_enable[5] && !r_reg.flags[5]) |=> !r_reg.flags[5];
	endproperty
	a_power_masked: assert property (p_power_masked) else $error("masked power flag set");

	// only the ready rising edge counts, a drop of the link must not flag
	property p_ready_no_fall;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(!r_reg.flags[0] && !(r_reg.sync2[0] && !r_reg.lvl_prev[0])) |=> !r_reg.flags[0];
	endproperty
	a_ready_no_fall: assert property (p_ready_no_fall) else $error("ready flag without rising edge");

	// flags only clear through a read of the flag register
	property p_flag_hold;
		@(posedge mclk_in) disable iff (!rst_n_in)
		!(reg_rd_in && reg_addr_in == 8'h0C) |=> (r_reg.flags & $past(r_reg.flags)) == $past(r_reg.flags);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");

	property p_enable_write;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_wr_in && reg_addr_in == 8'h0A) |=> r_reg.irq_enable == $past(reg_wdata_in[5:0]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write not taken");

	property p_enable_read;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_rd_in && reg_addr_in == 8'h0A) |=> reg_rdata_out == {2'b00, $past(r_reg.irq_enable)};
	endproperty
	a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

	property p_ctrl_read;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_rd_in && reg_addr_in == 8'h0B) |=> reg_rdata_out == {5'h00, $past(busy), 1'b0, $past(r_reg.cfg_load)};
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

	property p_busy_hold;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(r_reg.copy_state == PMICIS_WAIT && !copy_done_in) |=> copy_in_progress_out;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped before copy done");

	property p_load_ignored;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_wr_in && reg_addr_in == 8'h0B && busy) |=> $stable(cfg_from_serial_out);
	endproperty
	a_load_ignored: assert property (p_load_ignored) else $error("config select changed while busy");

	property p_start_pulse;
		@(posedge mclk_in) disable iff (!rst_n_in)
		copy_start_out |=> !copy_start_out;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("copy start longer than one cycle");

	property p_unmapped_read;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(reg_rd_in && (reg_addr_in < 8'h0A || reg_addr_in > 8'h0D)) |=> reg_rdata_out == 8'h00;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// >>> verif/pmicis_copy_model.sv
// shadow-copy engine model: done pulse a set delay after each start
`timescale 1ns/1ps
`default_nettype none
module pmicis_copy_model (
	input wire logic mclk_in, // clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic start_in, // copy start pulse
	input wire logic [7:0] delay_in, // cycles until done, 1 or more
	output logic done_out // one-cycle done pulse
);
	logic [7:0] cnt_reg;
	always_ff @(posedge mclk_in) begin
		done_out <= rst_n_in && !start_in && cnt_reg == 8'h01;
		if (!rst_n_in) begin
			cnt_reg <= 8'h00;
		end else if (start_in) begin
			cnt_reg <= delay_in;
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb_pmic_irq_status_ctrl.sv
// self-checking bench for the interrupt/status block against an integer model
`timescale 1ns/1ps
`default_nettype none
`include "pmicis_consts.svh"
module tb_pmic_irq_status_ctrl;
	logic mclk_in = 1'b0, rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, dly = 8'h14, rdata;
	logic wr = 1'b0, rd = 1'b0, chg = 1'b0, cold = 1'b1, pwr = 1'b0;
	logic [4:1] lv = 4'h0;
	logic done, start, cfg, busy, irq;
	int fail_count = 0, check_count = 0, en_m = 1, fl_m = 0;
	always #5 mclk_in = ~mclk_in;
	pmicis_ctrl DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .cold_start_done_in(cold),
		.batt_below_ovdis_in(lv[1]), .batt_above_ovch_in(lv[2]), .source_low_in(lv[3]),
		.temp_outside_in(lv[4]), .charge_enabled_in(chg), .power_result_ready_in(pwr),
		.copy_done_in(done), .copy_start_out(start), .cfg_from_serial_out(cfg),
		.copy_in_progress_out(busy), .irq_out(irq));
	pmicis_copy_model CPY (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .start_in(start),
		.delay_in(dly), .done_out(done));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_irq();
		chk("irq", {7'h00, (fl_m & en_m) != 0}, {7'h00, irq});
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask
	// a flag read clears the model's flags, as the design does
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1 chk(name, exp, rdata);
		if (a == `PMICIS_OFS_IRQ_FLAGS) fl_m = 0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		logic [4:1] nv;
		logic ev, nc;
		int n;
		void'($urandom(32'hD219));
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
		fl_m = 1; // ready seen high at release, enabled by default
		#1 chk_irq();
		rd_chk(`PMICIS_OFS_IRQ_ENABLE, 8'h01, "enable reset");
		rd_chk(`PMICIS_OFS_IRQ_FLAGS, 8'h01, "ready flag");
		chk_irq();
		for (int i = 0; i < 24; i++) begin
			en_m = $urandom & 63;
			wr_reg(`PMICIS_OFS_IRQ_ENABLE, 8'(en_m));
			nv = 4'($urandom);
			ev = 1'($urandom);
			nc = 1'($urandom);
			fl_m = fl_m | (int'({ev, nv ^ lv, nc & ~cold}) & en_m);
			lv <= nv;
			cold <= nc;
			chg <= 1'($urandom);
			pwr <= ev;
			@(posedge mclk_in);
			pwr <= 1'b0;
			repeat (8) @(posedge mclk_in);
			#1 chk_irq();
			rd_chk(`PMICIS_OFS_STATUS, {1'b0, chg, 1'b0, lv, 1'b0}, "status");
			rd_chk(`PMICIS_OFS_IRQ_ENABLE, 8'(en_m), "enable");
			rd_chk(`PMICIS_OFS_IRQ_FLAGS, 8'(fl_m), "flags");
			chk_irq();
		end
		rd_chk(8'h20, 8'h00, "unmapped");
		for (int k = 0; k < 2; k++) begin
			dly = (k == 0) ? 8'h14 : 8'h01;
			wr_reg(`PMICIS_OFS_CONFIG_LOAD, 8'h01);
			#1 chk("cfg", 8'h01, {7'h00, cfg});
			chk("busy", 8'h01, {7'h00, busy});
			if (k == 0) begin
				wr_reg(`PMICIS_OFS_CONFIG_LOAD, 8'h00);
				rd_chk(`PMICIS_OFS_CONFIG_LOAD, 8'h05, "ctrl busy");
			end
			// busy must drop once the model signals done
			for (n = 0; n < 50 && busy !== 1'b0; n++) @(negedge mclk_in);
			if (n == 50) begin
				fail_count++;
				conclude();
			end
			rd_chk(`PMICIS_OFS_CONFIG_LOAD, 8'h01, "ctrl done");
			wr_reg(`PMICIS_OFS_CONFIG_LOAD, 8'h00);
			#1 chk("cfg pins", 8'h00, {7'h00, cfg});
		end
		conclude();
	end
endmodule
`default_nettype wire
